//--- include/nvcfg_params.svh
// constants for the non-volatile configuration page block
// Operation
// - two 8-bit non-volatile user bytes at 28h and 29h hold any value
// - four non-volatile configuration registers at 30h through 33h
// - config bits 7..4 enable the 80k, 20k, 5k, 1.5k charge resistors
// - config bits 3..2 select the clock output frequency code
// - config bit 1 enables thermometer, bit 0 picks the scan period
// - offset, coefficient and turnover feed the frequency compensation logic
// - 31h is sign-magnitude offset: bit 7 fast, bits 6..0 magnitude 0..127
// - 32h holds the unsigned quadratic drift coefficient 0..255
// - 33h holds turnover temperature in bits 5..0; bits 7..6 unused
// - after power-on reset the stored page is copied into working registers
// - with thermometer disabled, host may write temperature register 20h
`ifndef NVCFG_PARAMS_SVH
`define NVCFG_PARAMS_SVH
`define NVCFG_A_USER0    8'h28
`define NVCFG_A_USER1    8'h29
`define NVCFG_A_CFG      8'h30
`define NVCFG_A_XOFS     8'h31
`define NVCFG_A_XCOEF    8'h32
`define NVCFG_A_XT0      8'h33
`define NVCFG_A_TEMP     8'h20
`define NVCFG_IDX_USER0  3'h0
`define NVCFG_IDX_USER1  3'h1
`define NVCFG_IDX_CFG    3'h2
`define NVCFG_IDX_XOFS   3'h3
`define NVCFG_IDX_XCOEF  3'h4
`define NVCFG_IDX_XT0    3'h5
`define NVCFG_NREG       6
`define NVCFG_NREG_W     3'h6
`define NVCFG_XT0_MASK   8'h3f
`define NVCFG_FULL_MASK  8'hff
`define NVCFG_ZERO       8'h00
`define NVCFG_B_THERM    1
`define NVCFG_B_SCAN     0
`define NVCFG_XOFS_SIGN  7
`endif

//--- include/nvcfg_pkg.sv
// types for the non-volatile configuration page block
package nvcfg_pkg;
  typedef enum logic [1:0] {NVCFG_LOAD, NVCFG_FETCH, NVCFG_RUN} nvcfg_state_t;
  typedef logic [7:0] nvcfg_byte_t;
endpackage

//--- include/nvcfg_load_if.sv
// storage load handshake between the page and its loader
`timescale 1ns/1ps
interface nvcfg_load_if;
  logic       ld_req;
  logic [2:0] ld_idx;
  logic [7:0] ld_data;
  logic       ld_we;
  logic       ld_done;
  modport loader (output ld_req, output ld_idx, input ld_data, output ld_we, output ld_done);
  modport page   (input ld_req, input ld_idx, output ld_data, input ld_we, input ld_done);
endinterface

//--- core/nvcfg_loader.sv
// sequencer that copies stored bytes into the working registers after reset
`timescale 1ns/1ps
`include "nvcfg_params.svh"
module nvcfg_loader (
  input  wire logic ref_clk,
  input  wire logic rst,
  input  wire logic supply_ok,
  nvcfg_load_if.loader lif
);
  nvcfg_pkg::nvcfg_state_t state_r;
  logic [2:0]              idx_r;
  wire last_w = (idx_r == `NVCFG_NREG_W - 3'h1);

  assign lif.ld_req  = (state_r == nvcfg_pkg::NVCFG_FETCH);
  assign lif.ld_idx  = idx_r;
  assign lif.ld_we   = lif.ld_req;
  assign lif.ld_done = (state_r == nvcfg_pkg::NVCFG_RUN);

  // ==========================================================
  // load sequence
  // copy stored page
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      state_r <= nvcfg_pkg::NVCFG_LOAD;
      idx_r   <= 3'h0;
    end
    else
    begin
      case (state_r)
        nvcfg_pkg::NVCFG_LOAD:  if (supply_ok) state_r <= nvcfg_pkg::NVCFG_FETCH;
        nvcfg_pkg::NVCFG_FETCH:
        begin
          idx_r <= last_w ? 3'h0 : idx_r + 3'h1;
          if (last_w) state_r <= nvcfg_pkg::NVCFG_RUN;
        end
        nvcfg_pkg::NVCFG_RUN:   state_r <= nvcfg_pkg::NVCFG_RUN;
        default:                state_r <= nvcfg_pkg::NVCFG_LOAD;
      endcase
    end
  end

  // ==========================================================
  // checks
  property p_load_len;
    @(posedge ref_clk) disable iff (rst)
      $rose(lif.ld_req) |-> lif.ld_req [*6] ##1 lif.ld_done;
  endproperty
  a_load_len: assert property (p_load_len) else $error("load not six bytes");
  c_load: cover property (@(posedge ref_clk) $rose(lif.ld_done));
endmodule // nvcfg_loader

//--- core/nvcfg_page.sv
// non-volatile user bytes and configuration page with working copies
`timescale 1ns/1ps
`include "nvcfg_params.svh"
module nvcfg_page (
  input  wire logic       ref_clk,
  input  wire logic       rst,
  input  wire logic       supply_ok,
  input  wire logic [7:0] store_rd_data,
  output logic      [2:0] store_rd_idx,
  output logic            store_rd_en,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  output logic      [7:0] reg_rdata,
  output logic            reg_hit,
  output logic            prog_start,
  output logic      [2:0] prog_idx,
  output logic      [7:0] prog_data,
  output logic            temp_wr,
  output logic      [7:0] temp_wdata,
  output logic            page_ready,
  output logic            charge_res_largest_en,
  output logic            charge_res_large_en,
  output logic            charge_res_medium_en,
  output logic            charge_res_small_en,
  output logic            clock_output_pin_sel_hi,
  output logic            clock_output_pin_sel_lo,
  output logic            therm_en,
  output logic            temp_scan_period_sel,
  output logic            crystal_offset_fast,
  output logic      [6:0] crystal_offset_mag,
  output logic      [7:0] crystal_quadratic_coef,
  output logic      [5:0] turnover_temperature
);
  nvcfg_load_if lif ();

  nvcfg_loader u_loader (
    .ref_clk   (ref_clk),
    .rst       (rst),
    .supply_ok (supply_ok),
    .lif       (lif)
  );

  // working copies of the six non-volatile bytes
  nvcfg_pkg::nvcfg_byte_t regs_r [`NVCFG_NREG];
  logic [7:0] rdata_r;
  logic       prog_r;
  logic [2:0] pidx_r;
  logic [7:0] pdata_r;
  logic       twr_r;
  logic [7:0] tdat_r;

  // ==========================================================
  // address decode
  // page byte and temperature register decode
  wire hit_u0 = (reg_addr == `NVCFG_A_USER0);
  wire hit_u1 = (reg_addr == `NVCFG_A_USER1);
  wire hit_cf = (reg_addr == `NVCFG_A_CFG);
  wire hit_xo = (reg_addr == `NVCFG_A_XOFS);
  wire hit_xc = (reg_addr == `NVCFG_A_XCOEF);
  wire hit_xt = (reg_addr == `NVCFG_A_XT0);
  wire hit_tp = (reg_addr == `NVCFG_A_TEMP);
  wire [2:0] sel_idx = hit_u0 ? `NVCFG_IDX_USER0 : hit_u1 ? `NVCFG_IDX_USER1 :
                       hit_cf ? `NVCFG_IDX_CFG : hit_xo ? `NVCFG_IDX_XOFS :
                       hit_xc ? `NVCFG_IDX_XCOEF : `NVCFG_IDX_XT0;
  wire page_hit = hit_u0 | hit_u1 | hit_cf | hit_xo | hit_xc | hit_xt;
  wire [7:0] wmask = hit_xt ? `NVCFG_XT0_MASK : `NVCFG_FULL_MASK;
  wire       wr_ok = reg_wr & page_hit & lif.ld_done;
  wire [7:0] cfg   = regs_r[`NVCFG_IDX_CFG];
  wire       tw_ok = reg_wr & hit_tp & ~cfg[`NVCFG_B_THERM] & lif.ld_done;
  // crystal bytes stay writable; hardware does not lock them
  wire [7:0] ld_val = (lif.ld_idx == `NVCFG_IDX_XT0) ? (lif.ld_data & `NVCFG_XT0_MASK) : lif.ld_data;

  assign lif.ld_data  = store_rd_data;
  assign store_rd_idx = lif.ld_idx;
  assign store_rd_en  = lif.ld_req;
  assign reg_hit      = page_hit | hit_tp;
  assign page_ready   = lif.ld_done;

  // ==========================================================
  // register storage: load from store, then host writes
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      for (int i = 0; i < `NVCFG_NREG; i++) regs_r[i] <= `NVCFG_ZERO;
    end
    else if (lif.ld_we)
      regs_r[lif.ld_idx] <= ld_val;
    else if (wr_ok)
      regs_r[sel_idx] <= reg_wdata & wmask;
  end

  // ==========================================================
  // read data, program request and temperature write
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      rdata_r <= `NVCFG_ZERO;
      prog_r  <= 1'b0;
      pidx_r  <= 3'h0;
      pdata_r <= `NVCFG_ZERO;
      twr_r   <= 1'b0;
      tdat_r  <= `NVCFG_ZERO;
    end
    else
    begin
      if (reg_rd) rdata_r <= page_hit ? regs_r[sel_idx] : `NVCFG_ZERO;
      prog_r  <= wr_ok;
      if (wr_ok)
      begin
        pidx_r  <= sel_idx;
        pdata_r <= reg_wdata & wmask;
      end
      twr_r   <= tw_ok;
      if (tw_ok) tdat_r <= reg_wdata;
    end
  end

  assign reg_rdata  = rdata_r;
  assign prog_start = prog_r;
  assign prog_idx   = pidx_r;
  assign prog_data  = pdata_r;
  assign temp_wr    = twr_r;
  assign temp_wdata = tdat_r;

  // ==========================================================
  // field outputs
  // charge resistor enables
  assign charge_res_largest_en  = cfg[7];
  assign charge_res_large_en    = cfg[6];
  assign charge_res_medium_en   = cfg[5];
  assign charge_res_small_en    = cfg[4];
  assign clock_output_pin_sel_hi          = cfg[3];
  assign clock_output_pin_sel_lo          = cfg[2];
  assign therm_en               = cfg[`NVCFG_B_THERM];
  assign temp_scan_period_sel   = cfg[`NVCFG_B_SCAN];
  assign crystal_offset_fast    = regs_r[`NVCFG_IDX_XOFS][`NVCFG_XOFS_SIGN];
  assign crystal_offset_mag     = regs_r[`NVCFG_IDX_XOFS][6:0];
  assign crystal_quadratic_coef = regs_r[`NVCFG_IDX_XCOEF];
  assign turnover_temperature   = regs_r[`NVCFG_IDX_XT0][5:0];

  // ==========================================================
  // checks
  property p_wr_prog;
    @(posedge ref_clk) disable iff (rst) wr_ok |=> prog_start && prog_data == $past(reg_wdata & wmask);
  endproperty
  a_wr_prog: assert property (p_wr_prog) else $error("write did not start program");
  property p_user_rt;
    @(posedge ref_clk) disable iff (rst) (wr_ok && hit_u1) |=> regs_r[`NVCFG_IDX_USER1] == $past(reg_wdata);
  endproperty
  a_user_rt: assert property (p_user_rt) else $error("user byte not stored");
  property p_cfg_wr;
    @(posedge ref_clk) disable iff (rst) (wr_ok && hit_cf) |=> charge_res_largest_en == $past(reg_wdata[7])
      && clock_output_pin_sel_lo == $past(reg_wdata[2]);
  endproperty
  a_cfg_wr: assert property (p_cfg_wr) else $error("config fields wrong");
  property p_clk_sel;
    @(posedge ref_clk) disable iff (rst) (wr_ok && hit_cf) |=> clock_output_pin_sel_hi == $past(reg_wdata[3]);
  endproperty
  a_clk_sel: assert property (p_clk_sel) else $error("clock select wrong");
  property p_temp_gate;
    @(posedge ref_clk) disable iff (rst) temp_wr |-> !$past(therm_en) && $past(reg_wr);
  endproperty
  a_temp_gate: assert property (p_temp_gate) else $error("temp written while enabled");
  property p_t0_top;
    @(posedge ref_clk) disable iff (rst) regs_r[`NVCFG_IDX_XT0][7:6] == 2'h0;
  endproperty
  a_t0_top: assert property (p_t0_top) else $error("turnover unused bits set");
  property p_ofs_wr;
    @(posedge ref_clk) disable iff (rst) (wr_ok && hit_xo) |=> crystal_offset_fast == $past(reg_wdata[7])
      && crystal_offset_mag == $past(reg_wdata[6:0]);
  endproperty
  a_ofs_wr: assert property (p_ofs_wr) else $error("offset fields wrong");
  property p_coef_wr;
    @(posedge ref_clk) disable iff (rst) (wr_ok && hit_xc) |=> crystal_quadratic_coef == $past(reg_wdata);
  endproperty
  a_coef_wr: assert property (p_coef_wr) else $error("coefficient wrong");
  property p_no_wr_early;
    @(posedge ref_clk) disable iff (rst) !page_ready |=> !prog_start;
  endproperty
  a_no_wr_early: assert property (p_no_wr_early) else $error("program before load");
  c_prog: cover property (@(posedge ref_clk) prog_start);
  c_temp: cover property (@(posedge ref_clk) temp_wr);
  c_ready: cover property (@(posedge ref_clk) $rose(page_ready));
endmodule // nvcfg_page

//--- verification/nvcfg_store_model.sv
// non-volatile storage model that answers the page's load fetches
`timescale 1ns/1ps
module nvcfg_store_model #(
  parameter logic [47:0] CONTENT = 48'h0
) (
  input  wire logic       ref_clk,
  input  wire logic       store_rd_en,
  input  wire logic [2:0] store_rd_idx,
  output logic      [7:0] store_rd_data
);
  logic [7:0] last_r = 8'h00;
  // stored byte per index, inverse of the last one when idle
  assign store_rd_data = (store_rd_en && store_rd_idx < 3'h6) ? CONTENT[8*store_rd_idx +: 8] : ~last_r;
  // remember the last byte handed out so an idle bus never looks valid
  always @(posedge ref_clk)
  begin
    if (store_rd_en)
    begin
      last_r <= store_rd_data;
    end
  end
endmodule // nvcfg_store_model

//--- verification/tb.sv
// self-checking bench for the non-volatile configuration page
`timescale 1ns/1ps
module tb;
  localparam logic [47:0] STORED = 48'h25_ff_f9_a6_c3_5a; // index 5 down to 0
  logic       ref_clk = 1'b0;
  logic       rst = 1'b1;
  logic       supply_ok = 1'b0;
  logic       reg_wr = 1'b0;
  logic       reg_rd = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic [7:0] store_rd_data, reg_rdata, prog_data, temp_wdata;
  wire  [7:0] cfg_seen, xofs_seen, coef_seen;
  logic [2:0] store_rd_idx, prog_idx;
  wire  [5:0] t0_seen;
  logic       store_rd_en, reg_hit, prog_start, temp_wr, page_ready;
  int         failures = 0;
  int         comparisons = 0;
  int         cycles = 0;

  // clock and hang guard
  always #25 ref_clk = ~ref_clk;
  always @(posedge ref_clk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      failures++;
      results();
    end
  end

  nvcfg_store_model #(.CONTENT(STORED)) u_store (.ref_clk(ref_clk), .store_rd_en(store_rd_en),
    .store_rd_idx(store_rd_idx), .store_rd_data(store_rd_data));

  nvcfg_page u_dut (.ref_clk(ref_clk), .rst(rst), .supply_ok(supply_ok), .store_rd_data(store_rd_data),
    .store_rd_idx(store_rd_idx), .store_rd_en(store_rd_en), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_hit(reg_hit),
    .prog_start(prog_start), .prog_idx(prog_idx), .prog_data(prog_data), .temp_wr(temp_wr),
    .temp_wdata(temp_wdata), .page_ready(page_ready), .charge_res_largest_en(cfg_seen[7]),
    .charge_res_large_en(cfg_seen[6]), .charge_res_medium_en(cfg_seen[5]),
    .charge_res_small_en(cfg_seen[4]), .clock_output_pin_sel_hi(cfg_seen[3]), .clock_output_pin_sel_lo(cfg_seen[2]),
    .therm_en(cfg_seen[1]), .temp_scan_period_sel(cfg_seen[0]), .crystal_offset_fast(xofs_seen[7]),
    .crystal_offset_mag(xofs_seen[6:0]), .crystal_quadratic_coef(coef_seen),
    .turnover_temperature(t0_seen));

  // ==========================================
  // shared compare and bus tasks
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    comparisons++;
    if (got !== exp)
    begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  // one write strobe, then the pulses that follow it; an idle edge keeps strobes apart
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic ep, input logic et);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(posedge ref_clk);
    #5;
    reg_wr = 1'b0;
    chk("prog_start", {7'h0, ep}, {7'h0, prog_start});
    chk("temp_wr", {7'h0, et}, {7'h0, temp_wr});
    @(posedge ref_clk);
    #5;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    reg_addr = a;
    reg_rd = 1'b1;
    @(posedge ref_clk);
    #5;
    reg_rd = 1'b0;
    chk("reg_rdata", exp, reg_rdata);
    @(posedge ref_clk);
    #5;
  endtask

  // ==========================================
  // scenarios
  task automatic test_load();
    logic [7:0] addrs [6] = '{8'h28, 8'h29, 8'h30, 8'h31, 8'h32, 8'h33};
    wr(8'h28, 8'h11, 1'b0, 1'b0);
    supply_ok = 1'b1;
    for (int i = 0; i < 6; i++)
    begin
      @(posedge ref_clk);
      #5;
      chk("store_rd_idx", {4'h0, 1'b1, i[2:0]}, {4'h0, store_rd_en, store_rd_idx});
    end
    chk("page_ready early", 8'h00, {7'h0, page_ready});
    @(posedge ref_clk);
    #5;
    chk("page_ready", 8'h01, {7'h0, page_ready});
    for (int i = 0; i < 6; i++)
    begin
      rd(addrs[i], STORED[8*i +: 8]);
    end
    chk("cfg fields", 8'ha6, cfg_seen);
    chk("offset fields", 8'hf9, xofs_seen);
    chk("coef", 8'hff, coef_seen);
    chk("turnover", 8'h25, {2'h0, t0_seen});
  endtask

  task automatic test_cfg();
    logic [7:0] d;
    for (int k = 0; k < 4; k++)
    begin
      d = {4'h1 << k, k[1:0], k[0], ~k[0]};
      wr(8'h30, d, 1'b1, 1'b0);
      chk("cfg fields", d, cfg_seen);
      chk("prog_data", d, prog_data);
      chk("prog_idx", 8'h02, {5'h0, prog_idx});
    end
    wr(8'h29, 8'h00, 1'b1, 1'b0);
    wr(8'h28, 8'hff, 1'b1, 1'b0);
    rd(8'h29, 8'h00);
    rd(8'h28, 8'hff);
  endtask

  task automatic test_xtal();
    wr(8'h31, 8'h79, 1'b1, 1'b0);
    chk("offset fields", 8'h79, xofs_seen);
    wr(8'h32, 8'h00, 1'b1, 1'b0);
    chk("coef", 8'h00, coef_seen);
    wr(8'h33, 8'hff, 1'b1, 1'b0);
    chk("prog_idx", 8'h05, {5'h0, prog_idx});
    rd(8'h33, 8'h3f);
    // factory values go back, as the host is meant to leave them
    wr(8'h31, 8'hf9, 1'b1, 1'b0);
    wr(8'h32, 8'hff, 1'b1, 1'b0);
    wr(8'h33, 8'h25, 1'b1, 1'b0);
  endtask

  task automatic test_temp();
    wr(8'h20, 8'h3c, 1'b0, 1'b0);
    wr(8'h30, 8'h00, 1'b1, 1'b0);
    wr(8'h20, 8'h3c, 1'b0, 1'b1);
    chk("temp_wdata", 8'h3c, temp_wdata);
    rd(8'h20, 8'h00);
    reg_addr = 8'h20;
    #1;
    chk("reg_hit temp", 8'h01, {7'h0, reg_hit});
    reg_addr = 8'h2a;
    #1;
    chk("reg_hit", 8'h00, {7'h0, reg_hit});
    @(posedge ref_clk);
    #5;
    wr(8'h2a, 8'hff, 1'b0, 1'b0);
    rd(8'h2a, 8'h00);
  endtask

  // reset in mid-run clears the working copies, then the stored page comes back
  task automatic test_reload();
    rst = 1'b1;
    supply_ok = 1'b0;
    repeat (2) @(posedge ref_clk);
    #5;
    rst = 1'b0;
    chk("page_ready after reset", 8'h00, {7'h0, page_ready});
    chk("coef after reset", 8'h00, coef_seen);
    supply_ok = 1'b1;
    repeat (7) @(posedge ref_clk);
    #5;
    chk("page_ready reload", 8'h01, {7'h0, page_ready});
    chk("cfg reload", 8'ha6, cfg_seen);
    chk("turnover reload", 8'h25, {2'h0, t0_seen});
    rd(8'h29, 8'hc3);
  endtask

  task automatic results();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // ==========================================
  // main sequence
  initial
  begin
    repeat (12) @(posedge ref_clk);
    #5;
    rst = 1'b0;
    test_load();
    test_cfg();
    test_xtal();
    test_temp();
    test_reload();
    results();
  end
endmodule // tb
